// File: design/ptpc_timer.sv
// periodic timer single pulse and capture logic
`timescale 1ns/1ps
module ptpc_timer #(
  parameter int INSTANCE = 0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ext_clock_pin,
  input wire logic capture_in_pin,
  input wire logic run_bit_set,
  input wire logic run_bit_clear,
  input wire logic mode_field_hi,
  input wire logic mode_field_lo,
  input wire logic edge_io_field_hi,
  input wire logic edge_io_field_lo,
  input wire logic capture_src_sel,
  input wire logic counter_clear_sel,
  input wire logic output_initial_level,
  input wire logic output_polarity,
  input wire logic [ptpc_pkg::PTPC_CNT_W-1:0] duty_compare_wdata,
  input wire logic duty_compare_we,
  input wire logic [ptpc_pkg::PTPC_CNT_W-1:0] period_compare_reg,
  input wire logic cmp_a_flag_clear,
  input wire logic cmp_p_flag_clear,
  output logic run_bit,
  output logic [ptpc_pkg::PTPC_CNT_W-1:0] counter_value,
  output logic [ptpc_pkg::PTPC_CNT_W-1:0] duty_compare_reg,
  output logic cmp_a_flag,
  output logic cmp_p_flag,
  output logic timer_out,
  output logic timer_out_en
);
  import ptpc_pkg::*;

  // ---------------------------------------------
  // pin synchroniser
  // ---------------------------------------------
  ptpc_sync_if sync_bus();

  ptpc_pin_sync u_sync (
    .clock(clock),
    .rst(rst),
    .ext_clock_pin(ext_clock_pin),
    .capture_in_pin(capture_in_pin),
    .sync(sync_bus)
  );

  // ---------------------------------------------
  // decode
  // ---------------------------------------------
  localparam logic [PTPC_CNT_W-1:0] CNT_MAX = (INSTANCE < 2) ? PTPC_MAX_10 : PTPC_MAX_16;

  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    logic hit;
    hit = 1'b0;
    case (sel)
      PTPC_EDGE_RISE: hit = rise;
      PTPC_EDGE_FALL: hit = fall;
      PTPC_EDGE_BOTH: hit = rise | fall;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  logic [1:0] mode;
  logic [1:0] edge_sel;
  logic pulse_mode;
  logic capture_mode;
  logic src_rise;
  logic src_fall;
  logic capture_hit;
  logic match_a;
  logic match_p;
  logic [PTPC_CNT_W-1:0] period_limit;
  logic [PTPC_CNT_W-1:0] duty_masked;
  logic run_reg;
  logic run_prev_reg;
  logic run_rise;
  logic [PTPC_CNT_W-1:0] cnt_reg;

  assign mode = {mode_field_hi, mode_field_lo};
  assign edge_sel = {edge_io_field_hi, edge_io_field_lo};
  assign pulse_mode = (mode == PTPC_MODE_PULSE);
  assign capture_mode = (mode == PTPC_MODE_CAPTURE);
  assign src_rise = capture_src_sel ? sync_bus.ext_clock_rise : sync_bus.capture_rise;
  assign src_fall = capture_src_sel ? sync_bus.ext_clock_fall : sync_bus.capture_fall;
  assign capture_hit = capture_mode & run_reg & edge_hit(edge_sel, src_rise, src_fall);
  assign duty_masked = duty_compare_reg & CNT_MAX;
  assign period_limit = ((period_compare_reg & CNT_MAX) == PTPC_CNT_RESET) ? CNT_MAX
                        : (period_compare_reg & CNT_MAX);
  // stale count on the start cycle must not match
  assign match_a = pulse_mode & run_reg & ~run_rise & (cnt_reg == duty_masked);
  assign match_p = capture_mode & run_reg & ~run_rise & (cnt_reg == period_limit);

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  logic run_next;
  logic run_prev_next;
  logic [PTPC_CNT_W-1:0] cnt_next;
  logic [PTPC_CNT_W-1:0] duty_reg;
  logic [PTPC_CNT_W-1:0] duty_next;
  logic flag_a_reg;
  logic flag_a_next;
  logic flag_p_reg;
  logic flag_p_next;
  logic out_reg;
  logic out_next;
  logic out_en_reg;
  logic out_en_next;
  ptpc_state_type state;

  assign run_rise = run_reg & ~run_prev_reg;
  assign state = run_reg ? PTPC_RUN : PTPC_IDLE;

  // ---------------------------------------------
  // run control
  // ---------------------------------------------
  always_comb begin
    run_next = run_reg;
    if (run_bit_clear) begin
      run_next = 1'b0;
    end
    if (match_a) begin
      run_next = 1'b0;
    end
    if (run_bit_set) begin
      run_next = 1'b1;
    end
    if (pulse_mode & sync_bus.ext_clock_rise) begin
      run_next = 1'b1;
    end
    run_prev_next = run_reg;
  end

  // ---------------------------------------------
  // counter
  // ---------------------------------------------
  always_comb begin
    cnt_next = cnt_reg;
    case (state)
      PTPC_IDLE: cnt_next = cnt_reg;
      PTPC_RUN: begin
        if (run_rise) begin
          cnt_next = PTPC_CNT_RESET;
        end else if (match_p) begin
          cnt_next = PTPC_CNT_RESET;
        end else if (cnt_reg == CNT_MAX) begin
          cnt_next = PTPC_CNT_RESET;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      default: cnt_next = cnt_reg;
    endcase
  end

  // ---------------------------------------------
  // capture and flags
  // ---------------------------------------------
  always_comb begin
    duty_next = duty_reg;
    if (duty_compare_we) begin
      duty_next = duty_compare_wdata & CNT_MAX;
    end
    if (capture_hit) begin
      duty_next = cnt_reg;
    end
    flag_a_next = flag_a_reg;
    if (cmp_a_flag_clear) begin
      flag_a_next = 1'b0;
    end
    if (match_a | capture_hit) begin
      flag_a_next = 1'b1;
    end
    flag_p_next = flag_p_reg;
    if (cmp_p_flag_clear) begin
      flag_p_next = 1'b0;
    end
    if (match_p) begin
      flag_p_next = 1'b1;
    end
  end

  // ---------------------------------------------
  // pin output, enabled in pulse mode, level is run xnor output_initial_level, xor output_polarity
  // ---------------------------------------------
  always_comb begin
    out_next = 1'b0;
    out_en_next = 1'b0;
    if (pulse_mode) begin
      out_en_next = 1'b1;
      out_next = (run_next ~^ output_initial_level) ^ output_polarity;
    end
  end

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      run_reg <= 1'b0;
      run_prev_reg <= 1'b0;
      cnt_reg <= PTPC_CNT_RESET;
      duty_reg <= PTPC_CNT_RESET;
      flag_a_reg <= 1'b0;
      flag_p_reg <= 1'b0;
      out_reg <= 1'b0;
      out_en_reg <= 1'b0;
    end else begin
      run_reg <= run_next;
      run_prev_reg <= run_prev_next;
      cnt_reg <= cnt_next;
      duty_reg <= duty_next;
      flag_a_reg <= flag_a_next;
      flag_p_reg <= flag_p_next;
      out_reg <= out_next;
      out_en_reg <= out_en_next;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign run_bit = run_reg;
  assign counter_value = cnt_reg;
  assign duty_compare_reg = duty_reg;
  assign cmp_a_flag = flag_a_reg;
  assign cmp_p_flag = flag_p_reg;
  assign timer_out = out_reg;
  assign timer_out_en = out_en_reg;
endmodule

// File: design/ptpc_pkg.sv
// package of constants and types for the periodic timer pulse/capture block
// Functional notes
// - pulse mode: ext clock rising edge sets run
// - run rise starts counter, raises pulse
// - compare A clears run, ends pulse
// - pulse mode compare A sets A flag
// - pulse mode: counter zeroed on start and at maximum
// - source select picks capture pin or clock
// - edge field picks rising, falling, both
// - edge field 11: no capture, counter runs
// - capture counter runs from run rise to fall
// - selected edge copies counter, sets A flag
// - period match wraps counter, sets P flag
// - period zero: count to full maximum
// - instances 0,1 ten bit; 2,3 sixteen bit
// - capture mode ignores output bits, no drive
// - capture pin edges seen even when output
// - select 0 capture pin, 1 clock pin
// - maximum 0x3FF or 0xFFFF
package ptpc_pkg;
  localparam int PTPC_CNT_W = 16;
  localparam logic [PTPC_CNT_W-1:0] PTPC_MAX_10 = 16'h03FF;
  localparam logic [PTPC_CNT_W-1:0] PTPC_MAX_16 = 16'hFFFF;
  localparam logic [1:0] PTPC_MODE_CAPTURE = 2'h1;
  localparam logic [1:0] PTPC_MODE_PULSE = 2'h2;
  localparam logic [1:0] PTPC_EDGE_RISE = 2'h0;
  localparam logic [1:0] PTPC_EDGE_FALL = 2'h1;
  localparam logic [1:0] PTPC_EDGE_BOTH = 2'h2;
  localparam logic [1:0] PTPC_EDGE_NONE = 2'h3;
  localparam logic [PTPC_CNT_W-1:0] PTPC_CNT_RESET = 16'h0000;
  typedef enum {PTPC_IDLE, PTPC_RUN} ptpc_state_type;
endpackage

// File: design/ptpc_sync_if.sv
// interface carrying the synchronised ext clock level and edge pulses of both pins
`timescale 1ns/1ps
interface ptpc_sync_if;
  logic ext_clock_level;
  logic ext_clock_rise;
  logic ext_clock_fall;
  logic capture_rise;
  logic capture_fall;
  modport src (output ext_clock_level, ext_clock_rise, ext_clock_fall, capture_rise, capture_fall);
  modport dst (input ext_clock_level, ext_clock_rise, ext_clock_fall, capture_rise, capture_fall);
endinterface

// File: design/ptpc_pin_sync.sv
// two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module ptpc_pin_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic ext_clock_pin,
  input wire logic capture_in_pin,
  ptpc_sync_if.src sync
);
  import ptpc_pkg::*;
  logic [1:0] meta_reg;
  logic [1:0] meta_next;
  logic [1:0] stable_reg;
  logic [1:0] stable_next;
  logic [1:0] prev_reg;
  logic [1:0] prev_next;

  // ---------------------------------------------
  // synchroniser next state
  // ---------------------------------------------
  always_comb begin
    meta_next = {capture_in_pin, ext_clock_pin};
    stable_next = meta_reg;
    prev_next = stable_reg;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_reg <= 2'h0;
      stable_reg <= 2'h0;
      prev_reg <= 2'h0;
    end else begin
      meta_reg <= meta_next;
      stable_reg <= stable_next;
      prev_reg <= prev_next;
    end
  end

  // ---------------------------------------------
  // edge pulses
  // ---------------------------------------------
  assign sync.ext_clock_level = stable_reg[0];
  assign sync.ext_clock_rise = stable_reg[0] & ~prev_reg[0];
  assign sync.ext_clock_fall = ~stable_reg[0] & prev_reg[0];
  assign sync.capture_rise = stable_reg[1] & ~prev_reg[1];
  assign sync.capture_fall = ~stable_reg[1] & prev_reg[1];
endmodule

// File: testbench/ptpc_timer_assertions.sv
// checker for the pulse and capture timer ports
`timescale 1ns/1ps
module ptpc_timer_assertions #(
  parameter int INSTANCE = 0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ext_clock_pin,
  input wire logic run_bit_set,
  input wire logic mode_field_hi,
  input wire logic mode_field_lo,
  input wire logic edge_io_field_hi,
  input wire logic edge_io_field_lo,
  input wire logic duty_compare_we,
  input wire logic [ptpc_pkg::PTPC_CNT_W-1:0] period_compare_reg,
  input wire logic cmp_a_flag_clear,
  input wire logic run_bit,
  input wire logic [ptpc_pkg::PTPC_CNT_W-1:0] counter_value,
  input wire logic [ptpc_pkg::PTPC_CNT_W-1:0] duty_compare_reg,
  input wire logic cmp_a_flag,
  input wire logic cmp_p_flag,
  input wire logic timer_out_en
);
  import ptpc_pkg::*;
  localparam logic [PTPC_CNT_W-1:0] max_count = (INSTANCE < 2) ? PTPC_MAX_10 : PTPC_MAX_16;
  wire cap = {mode_field_hi, mode_field_lo} == PTPC_MODE_CAPTURE;
  wire pul = {mode_field_hi, mode_field_lo} == PTPC_MODE_PULSE;
  wire [PTPC_CNT_W-1:0] top = (period_compare_reg == PTPC_CNT_RESET) ? max_count : period_compare_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ----------
  // properties
  // ----------
  property p_start; run_bit_set |=> run_bit; endproperty
  a_start: assert property (p_start) else $error("run not set");
  property p_pin; pul && $rose(ext_clock_pin) |-> ##[1:5] run_bit; endproperty
  a_pin: assert property (p_pin) else $error("pin did not start");
  property p_zero; $rose(run_bit) |=> counter_value == PTPC_CNT_RESET; endproperty
  a_zero: assert property (p_zero) else $error("counter not zeroed");
  property p_hold; !run_bit |=> $stable(counter_value); endproperty
  a_hold: assert property (p_hold) else $error("counter moved while stopped");
  property p_end;
    pul && run_bit && $past(run_bit) && !run_bit_set && counter_value == (duty_compare_reg & max_count)
      |=> !run_bit && cmp_a_flag;
  endproperty
  a_end: assert property (p_end) else $error("pulse did not end");
  property p_nocap;
    cap && {edge_io_field_hi, edge_io_field_lo} == PTPC_EDGE_NONE && !duty_compare_we |=> $stable(duty_compare_reg);
  endproperty
  a_nocap: assert property (p_nocap) else $error("capture while disabled");
  property p_wrap; cap && run_bit && $past(run_bit) && counter_value == top |=> !counter_value && cmp_p_flag; endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");
  property p_sticky; cmp_a_flag && !cmp_a_flag_clear |=> cmp_a_flag; endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  property p_noout; cap |=> !timer_out_en; endproperty
  a_noout: assert property (p_noout) else $error("output driven in capture");
  cover property ($fell(run_bit) && cmp_a_flag);
  cover property (cap && $rose(cmp_p_flag));
  cover property (cap && $changed(duty_compare_reg));
endmodule
bind ptpc_timer ptpc_timer_assertions #(.INSTANCE(INSTANCE)) ptpc_timer_assertions_inst (.clock(clock), .rst(rst),
  .ext_clock_pin(ext_clock_pin), .run_bit_set(run_bit_set), .mode_field_hi(mode_field_hi),
  .mode_field_lo(mode_field_lo), .edge_io_field_hi(edge_io_field_hi), .edge_io_field_lo(edge_io_field_lo),
  .duty_compare_we(duty_compare_we), .period_compare_reg(period_compare_reg), .cmp_a_flag_clear(cmp_a_flag_clear),
  .run_bit(run_bit), .counter_value(counter_value), .duty_compare_reg(duty_compare_reg), .cmp_a_flag(cmp_a_flag),
  .cmp_p_flag(cmp_p_flag), .timer_out_en(timer_out_en));

// File: testbench/ptpc_pin_model.sv
// model of the external trigger and capture pins
`timescale 1ns/1ps
module ptpc_pin_model (
  input wire logic clock,
  input wire logic ext_req,
  input wire logic cap_req,
  output logic ext_clock_pin,
  output logic capture_in_pin
);
  initial ext_clock_pin = 1'h0;
  initial capture_in_pin = 1'h0;
  // each request flips a pin: rise and fall in turn
  always @(posedge clock) begin
    if (ext_req)
      ext_clock_pin <= ~ext_clock_pin;
    if (cap_req)
      capture_in_pin <= ~capture_in_pin;
  end
endmodule

// File: testbench/tb.sv
// self-checking bench for the pulse and capture timer
`timescale 1ns/1ps
module tb;
  import ptpc_pkg::*;
  logic clock = 1'h0, rst = 1'h1, we = 1'h0, src = 1'h0, pol = 1'h0, ext_clock_pin, capture_in_pin;
  logic [5:0] req = 6'h00;
  logic [1:0] mode = PTPC_MODE_PULSE, edge_f = PTPC_EDGE_NONE;
  logic [PTPC_CNT_W-1:0] period = 16'h0000, snap, counter_value, duty_compare_reg;
  logic run_bit, cmp_a_flag, cmp_p_flag, timer_out, timer_out_en;
  int n_mismatch = 0, total_checks = 0, cycles = 0, k;
  always #10 clock = ~clock;
  ptpc_timer #(.INSTANCE(0)) ptpc_timer_inst (.clock(clock), .rst(rst), .ext_clock_pin(ext_clock_pin),
    .capture_in_pin(capture_in_pin), .run_bit_set(req[0]), .run_bit_clear(req[1]), .mode_field_hi(mode[1]),
    .mode_field_lo(mode[0]), .edge_io_field_hi(edge_f[1]), .edge_io_field_lo(edge_f[0]), .capture_src_sel(src),
    .counter_clear_sel(1'h1), .output_initial_level(1'h1), .output_polarity(pol), .duty_compare_wdata(16'h0005),
    .duty_compare_we(we), .period_compare_reg(period), .cmp_a_flag_clear(req[2]), .cmp_p_flag_clear(req[3]),
    .run_bit(run_bit), .counter_value(counter_value), .duty_compare_reg(duty_compare_reg), .cmp_a_flag(cmp_a_flag),
    .cmp_p_flag(cmp_p_flag), .timer_out(timer_out), .timer_out_en(timer_out_en));
  ptpc_pin_model ptpc_pin_model_inst (.clock(clock), .ext_req(req[4]), .cap_req(req[5]),
    .ext_clock_pin(ext_clock_pin), .capture_in_pin(capture_in_pin));
  // -----
  // tasks
  // -----
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // strobes: set, clear, a clear, p clear, ext flip, cap flip
  task automatic hit(input logic [5:0] m);
    req <= m;
    tick(1);
    req <= 6'h00;
    tick(1);
  endtask
  task automatic wait_run(input logic v);
    k = 0;
    while (run_bit !== v && k < 50) begin
      tick(1);
      k++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    tick(3);
    rst <= 1'h0;
    we <= 1'h1;
    tick(1);
    we <= 1'h0;
    hit(6'h01);
    chk("out_on", 16'h1, {timer_out_en, timer_out} == 2'h3);
    wait_run(1'h0);
    chk("width", 16'h7, k);
    chk("a_flag", 16'h1, {cmp_a_flag, timer_out} == 2'h2);
    hit(6'h04);
    chk("a_clear", 16'h0, cmp_a_flag);
    hit(6'h10);
    wait_run(1'h1);
    chk("pin_run", 16'h1, run_bit);
    wait_run(1'h0);
    hit(6'h10);
    tick(8);
    chk("fall_run", 16'h0, run_bit);
    pol <= 1'h1;
    hit(6'h01);
    chk("pol_on", 16'h2, {timer_out_en, timer_out});
    wait_run(1'h0);
    chk("pol_off", 16'h3, {timer_out_en, timer_out});
    mode <= PTPC_MODE_CAPTURE;
    hit(6'h0D);
    tick(20);
    chk("out_en", 16'h0, timer_out_en);
    for (int e = 0; e < 8; e++) begin
      edge_f <= 2'(e / 2);
      snap = counter_value;
      hit(6'h24);
      tick(6);
      // pin flips each pass: rise on even, fall on odd
      chk("cap_flag", 16'(e == 0 || e == 3 || e == 4 || e == 5), cmp_a_flag);
      if (e == 0)
        chk("cap_val", 16'h1, duty_compare_reg > snap && duty_compare_reg - snap < 16'h0008);
    end
    src <= 1'h1;
    edge_f <= PTPC_EDGE_BOTH;
    hit(6'h24);
    tick(6);
    chk("src_cap", 16'h0, cmp_a_flag);
    hit(6'h10);
    tick(6);
    chk("src_ext", 16'h1, cmp_a_flag);
    period <= 16'h0008;
    hit(6'h02);
    snap = counter_value;
    tick(3);
    chk("hold", snap, counter_value);
    hit(6'h09);
    tick(12);
    chk("p_flag", 16'h1, cmp_p_flag && counter_value <= 16'h0008);
    period <= 16'h0000;
    hit(6'h08);
    tick(1100);
    chk("p_full", 16'h1, cmp_p_flag);
    summarize();
  end
endmodule
